//--- core/ptc_top.sv
// Periodic tick counter: registers, 8-bit counter, modulo match and interrupt
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`include "ptc_defs.svh"

// Operation
// - Count readable, writes to it ignored
// - Count clears on reset, limit writes or select writes that change the select
// - Prescaler tick with count equal to limit: clear, set flag
// - Limit zero flags every prescaler output edge
// - Limit write restarts prescaler and counter
// - Limit resets to zero
// - After reset counter stopped, prescaler off
// - Low-power oscillator is default source
// - Nonzero prescale select starts prescaler
// - Clock select picks one of three sources
// - Changed clock select restarts prescaler, counter
// - 8-bit up-counter fed by binary/decimal prescaler
// - Software enable gates flag onto interrupt
module ptc_top #(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tick_irq
);
  import ptc_pkg::*;

  ptc_reg_if rif ();

  // ****************************************
  // Register state
  // ****************************************
  ptc_byte_t current_count_q;
  ptc_byte_t current_count_d;
  ptc_byte_t match_limit_q;
  ptc_src_e clock_select_q;
  ptc_ps_t prescale_select_q;
  logic tick_flag_q;
  logic tick_flag_d;
  logic tick_mask_q;
  logic prescale_tick;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_lane0 = rif.wr_en && rif.wr_strb[0];
  wire wr_status = wr_lane0 && (rif.wr_addr == `PTC_OFS_STATUS);
  wire wr_mask = wr_lane0 && (rif.wr_addr == `PTC_OFS_MASK);
  wire wr_config = wr_lane0 && (rif.wr_addr == `PTC_OFS_CONFIG);
  wire wr_limit = wr_lane0 && (rif.wr_addr == `PTC_OFS_LIMIT);
  wire wr_known = (rif.wr_addr == `PTC_OFS_STATUS) || (rif.wr_addr == `PTC_OFS_MASK)
    || (rif.wr_addr == `PTC_OFS_CONFIG) || (rif.wr_addr == `PTC_OFS_COUNT)
    || (rif.wr_addr == `PTC_OFS_LIMIT);
  wire [1:0] new_cs_raw = rif.wr_data[`PTC_CS_MSB:`PTC_CS_LSB];
  wire ptc_src_e new_cs = (new_cs_raw == 2'h1) ? PTC_SRC_EXTERNAL :
    (new_cs_raw == 2'h2) ? PTC_SRC_INTERNAL : PTC_SRC_LOW_POWER;
  wire ptc_ps_t new_ps = rif.wr_data[`PTC_PS_MSB:`PTC_PS_LSB];
  wire cfg_change = wr_config
    && ((new_cs != clock_select_q) || (new_ps != prescale_select_q));
  wire restart = wr_limit || cfg_change;
  wire flag_clear = wr_status && rif.wr_data[`PTC_TICK_FLAG_BIT];

  assign rif.wr_err = !wr_known;

  // ****************************************
  // Prescaler
  // ****************************************
  ptc_prescaler #(
    .DIV_W(DIV_W)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .low_power_osc_clock(low_power_osc_clock),
    .external_ref_clock(external_ref_clock),
    .internal_ref_clock(internal_ref_clock),
    .clock_select(clock_select_q),
    .prescale_select(prescale_select_q),
    .restart(restart),
    .tick(prescale_tick)
  );

  // ****************************************
  // Counter and match
  // ****************************************
  wire match = prescale_tick && (current_count_q == match_limit_q);

  always_comb begin
    current_count_d = current_count_q;
    if (restart) begin
      current_count_d = `PTC_COUNT_RST;
    end else if (match) begin
      current_count_d = `PTC_COUNT_RST;
    end else if (prescale_tick) begin
      current_count_d = current_count_q + 8'h01;
    end
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    tick_flag_d = tick_flag_q;
    if (flag_clear) begin
      tick_flag_d = 1'b0;
    end
    if (match) begin
      tick_flag_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_count_q <= `PTC_COUNT_RST;
      tick_flag_q <= 1'b0;
    end else begin
      current_count_q <= current_count_d;
      tick_flag_q <= tick_flag_d;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_limit_q <= `PTC_LIMIT_RST;
      clock_select_q <= PTC_SRC_LOW_POWER;
      prescale_select_q <= `PTC_PS_RST;
      tick_mask_q <= `PTC_MASK_RST;
    end else begin
      if (wr_limit) begin
        match_limit_q <= rif.wr_data[7:0];
      end
      if (wr_config) begin
        clock_select_q <= new_cs;
        prescale_select_q <= new_ps;
      end
      if (wr_mask) begin
        tick_mask_q <= rif.wr_data[`PTC_TICK_FLAG_BIT];
      end
    end
  end

  assign tick_irq = tick_flag_q && tick_mask_q;

  // ****************************************
  // Read mux
  // ****************************************
  wire rd_status = (rif.rd_addr == `PTC_OFS_STATUS);
  wire rd_mask = (rif.rd_addr == `PTC_OFS_MASK);
  wire rd_config = (rif.rd_addr == `PTC_OFS_CONFIG);
  wire rd_count = (rif.rd_addr == `PTC_OFS_COUNT);
  wire rd_limit = (rif.rd_addr == `PTC_OFS_LIMIT);
  wire [31:0] cfg_word = {26'h0, clock_select_q, prescale_select_q};

  assign rif.rd_data = rd_status ? {31'h0, tick_flag_q} :
    rd_mask ? {31'h0, tick_mask_q} :
    rd_config ? cfg_word :
    rd_count ? {24'h0, current_count_q} :
    rd_limit ? {24'h0, match_limit_q} : 32'h00000000;
  assign rif.rd_err = !(rd_status || rd_mask || rd_config || rd_count || rd_limit);

  // ****************************************
  // Bus slave
  // ****************************************
  ptc_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );
endmodule

//--- core/ptc_defs.svh
// Register offsets, field positions, reset values and divide ratios of the tick counter
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PTC_OFS_STATUS 8'h00
`define PTC_OFS_MASK 8'h04
`define PTC_OFS_CONFIG 8'h08
`define PTC_OFS_COUNT 8'h0C
`define PTC_OFS_LIMIT 8'h10

// ****************************************
// Field positions
// ****************************************
`define PTC_TICK_FLAG_BIT 0
`define PTC_PS_LSB 0
`define PTC_PS_MSB 3
`define PTC_CS_LSB 4
`define PTC_CS_MSB 5

// ****************************************
// Reset values
// ****************************************
`define PTC_COUNT_RST 8'h00
`define PTC_LIMIT_RST 8'h00
`define PTC_PS_RST 4'h0
`define PTC_CS_RST 2'h0
`define PTC_MASK_RST 1'b0

// ****************************************
// Decimal divide ratios, prescale codes 8 to 15
// ****************************************
`define PTC_DEC_DIV_8 10'd1
`define PTC_DEC_DIV_9 10'd2
`define PTC_DEC_DIV_10 10'd5
`define PTC_DEC_DIV_11 10'd10
`define PTC_DEC_DIV_12 10'd20
`define PTC_DEC_DIV_13 10'd50
`define PTC_DEC_DIV_14 10'd100
`define PTC_DEC_DIV_15 10'd1000

`endif

//--- core/ptc_pkg.sv
// Types shared by the tick counter modules
package ptc_pkg;
  typedef enum logic [1:0] {
    PTC_SRC_LOW_POWER,
    PTC_SRC_EXTERNAL,
    PTC_SRC_INTERNAL
  } ptc_src_e;
  typedef logic [3:0] ptc_ps_t;
  typedef logic [7:0] ptc_byte_t;
endpackage

//--- core/ptc_reg_if.sv
// Register access carrier between bus slave and counter core
interface ptc_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

//--- core/ptc_axil_slave.sv
// AXI4-Lite slave front end feeding the register carrier
module ptc_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ptc_reg_if.bus rif
);
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rif.wr_en = do_write;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_en = ar_take;
  assign rif.rd_addr = s_axi_araddr;

  // ****************************************
  // Write channels, taken in either order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= rif.wr_err ? 2'h2 : 2'h0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rif.rd_data;
      rresp_q <= rif.rd_err ? 2'h2 : 2'h0;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

//--- core/ptc_prescaler.sv
// Clock source selector and binary or decimal prescaler
`include "ptc_defs.svh"
module ptc_prescaler #(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire ptc_pkg::ptc_src_e clock_select,
  input wire ptc_pkg::ptc_ps_t prescale_select,
  input wire logic restart,
  output logic tick
);
  import ptc_pkg::*;
  logic [2:0] src_prev_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_cnt_d;
  logic [DIV_W-1:0] divisor;
  logic sel_level;
  logic sel_prev;
  wire src_edge = sel_level && !sel_prev;
  wire running = (prescale_select != 4'h0);
  wire last = (div_cnt_q >= divisor - DIV_W'(1));

  // ****************************************
  // Source selection
  // ****************************************
  always_comb begin
    case (clock_select)
      PTC_SRC_EXTERNAL: begin
        sel_level = external_ref_clock;
        sel_prev = src_prev_q[1];
      end
      PTC_SRC_INTERNAL: begin
        sel_level = internal_ref_clock;
        sel_prev = src_prev_q[2];
      end
      default: begin
        sel_level = low_power_osc_clock;
        sel_prev = src_prev_q[0];
      end
    endcase
  end

  // ****************************************
  // Divide ratio: codes 1-7 binary, 8-15 decimal
  // ****************************************
  always_comb begin
    case (prescale_select)
      4'h8: divisor = DIV_W'(`PTC_DEC_DIV_8);
      4'h9: divisor = DIV_W'(`PTC_DEC_DIV_9);
      4'hA: divisor = DIV_W'(`PTC_DEC_DIV_10);
      4'hB: divisor = DIV_W'(`PTC_DEC_DIV_11);
      4'hC: divisor = DIV_W'(`PTC_DEC_DIV_12);
      4'hD: divisor = DIV_W'(`PTC_DEC_DIV_13);
      4'hE: divisor = DIV_W'(`PTC_DEC_DIV_14);
      4'hF: divisor = DIV_W'(`PTC_DEC_DIV_15);
      default: divisor = DIV_W'(1) << prescale_select[2:0];
    endcase
  end

  always_comb begin
    div_cnt_d = div_cnt_q;
    if (restart || !running) begin
      div_cnt_d = '0;
    end else if (src_edge) begin
      div_cnt_d = last ? '0 : div_cnt_q + DIV_W'(1);
    end
  end

  assign tick = running && !restart && src_edge && last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 3'h0;
      div_cnt_q <= '0;
    end else begin
      src_prev_q <= {internal_ref_clock, external_ref_clock, low_power_osc_clock};
      div_cnt_q <= div_cnt_d;
    end
  end
endmodule

//--- testbench/ptc_top_chk.sv
// Bus handshake and interrupt checker for the tick counter
module ptc_top_chk #(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tick_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Properties
  // ****************************************
  a_reset_idle: assert property (
    $rose(aresetn) |-> !tick_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_bad: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_clear: assert property ($fell(tick_irq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
endmodule

bind ptc_top ptc_top_chk #(.DIV_W(DIV_W)) ptc_top_chk_inst (.*);

//--- testbench/test_ptc_top.sv
// Self-checking bench of the tick counter
`include "ptc_defs.svh"
module test_ptc_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} ptc_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] src = 3'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  int error_cnt = 0;
  int samples_checked = 0;
  ptc_row_s rows [14] = '{
    '{1'b0, `PTC_OFS_STATUS, 32'h0, 2'h0},
    '{1'b0, `PTC_OFS_MASK, 32'h0, 2'h0},
    '{1'b0, `PTC_OFS_CONFIG, 32'h0, 2'h0},
    '{1'b0, `PTC_OFS_COUNT, 32'h0, 2'h0},
    '{1'b0, `PTC_OFS_LIMIT, 32'h0, 2'h0},
    '{1'b1, `PTC_OFS_COUNT, 32'hFF, 2'h0},
    '{1'b0, `PTC_OFS_COUNT, 32'h0, 2'h0},
    '{1'b1, `PTC_OFS_LIMIT, 32'hA5, 2'h0},
    '{1'b0, `PTC_OFS_LIMIT, 32'hA5, 2'h0},
    '{1'b1, 8'h14, 32'h1, 2'h2},
    '{1'b0, 8'h14, 32'h0, 2'h2},
    '{1'b1, `PTC_OFS_CONFIG, 32'h3F, 2'h0},
    '{1'b0, `PTC_OFS_CONFIG, 32'h0F, 2'h0},
    '{1'b0, `PTC_OFS_COUNT, 32'h0, 2'h0}};

  ptc_top ptc_top_inst (
    .low_power_osc_clock(src[0]),
    .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]),
    .*);

  always #5 aclk = ~aclk;

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic test_done;
    $display("checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tmo;
    error_cnt++;
    test_done();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rv = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    dv = s_axi_rdata;
    rv = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] dv);
    wr(a, dv, r);
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic c(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, 32'h0);
  endtask

  // Read with rready held back two cycles after rvalid
  task automatic rd_late(input logic [7:0] a, output logic [31:0] dv);
    int n;
    int seen;
    seen = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) seen++;
      if (seen == 2) s_axi_rready <= 1'b1;
    end
    dv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
  endtask

  // Write with bready held back two cycles after bvalid
  task automatic wr_late(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
    int n;
    int seen;
    seen = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) seen++;
      if (seen == 2) s_axi_bready <= 1'b1;
    end
    rv = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
  endtask

  // Source edges slow enough for the edge detector
  task automatic pulse(input int s, input int k);
    repeat (k) begin
      @(posedge aclk);
      src[s] <= 1'b1;
      repeat (2) @(posedge aclk);
      src[s] <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, r);
      end else begin
        rd(rows[i].a, d, r);
        chk(d, rows[i].d);
      end
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    w(`PTC_OFS_LIMIT, 32'h5);
    w(`PTC_OFS_CONFIG, 32'h08);
    pulse(0, 2);
    c(`PTC_OFS_COUNT, 32'h2);
    pulse(1, 2);
    c(`PTC_OFS_COUNT, 32'h2);
    w(`PTC_OFS_CONFIG, 32'h18);
    c(`PTC_OFS_COUNT, 32'h0);
    pulse(1, 3);
    w(`PTC_OFS_CONFIG, 32'h18);
    c(`PTC_OFS_COUNT, 32'h3);
    w(`PTC_OFS_LIMIT, 32'h3);
    c(`PTC_OFS_COUNT, 32'h0);
    pulse(1, 3);
    c(`PTC_OFS_COUNT, 32'h3);
    c(`PTC_OFS_STATUS, 32'h0);
    pulse(1, 1);
    c(`PTC_OFS_COUNT, 32'h0);
    c(`PTC_OFS_STATUS, 32'h1);
    chk({31'h0, tick_irq}, 32'h0);
    w(`PTC_OFS_MASK, 32'h1);
    chk({31'h0, tick_irq}, 32'h1);
    w(`PTC_OFS_STATUS, 32'h0);
    chk({31'h0, tick_irq}, 32'h1);
    w(`PTC_OFS_STATUS, 32'h1);
    chk({31'h0, tick_irq}, 32'h0);
    w(`PTC_OFS_LIMIT, 32'h0);
    w(`PTC_OFS_CONFIG, 32'h28);
    pulse(2, 1);
    c(`PTC_OFS_STATUS, 32'h1);
    w(`PTC_OFS_STATUS, 32'h1);
    pulse(2, 1);
    c(`PTC_OFS_STATUS, 32'h1);
    c(`PTC_OFS_COUNT, 32'h0);
    w(`PTC_OFS_LIMIT, 32'h10);
    w(`PTC_OFS_CONFIG, 32'h21);
    pulse(2, 3);
    c(`PTC_OFS_COUNT, 32'h1);
    pulse(2, 1);
    c(`PTC_OFS_COUNT, 32'h2);
    w(`PTC_OFS_CONFIG, 32'h20);
    pulse(2, 3);
    c(`PTC_OFS_COUNT, 32'h0);
    w(`PTC_OFS_CONFIG, 32'h0A);
    pulse(0, 5);
    c(`PTC_OFS_COUNT, 32'h1);
    rd_late(`PTC_OFS_LIMIT, d);
    chk(d, 32'h10);
    chk({31'h0, tick_irq}, 32'h1);
    wr_late(`PTC_OFS_MASK, 32'h0, r);
    chk({30'h0, r}, 32'h0);
    chk({31'h0, tick_irq}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({31'h0, tick_irq}, 32'h0);
    c(`PTC_OFS_LIMIT, 32'h0);
    c(`PTC_OFS_CONFIG, 32'h0);
    c(`PTC_OFS_MASK, 32'h0);
    pulse(0, 2);
    c(`PTC_OFS_COUNT, 32'h0);
    test_done();
  end
endmodule
